// File: core/fpcls_pkg.sv
package fpcls_pkg;

    localparam int FPCLS_NREG = 32;
    localparam int FPCLS_NDBL = 16;

    localparam int SP_EXP_W = 8;
    localparam int SP_FRAC_W = 23;
    localparam int SP_BIAS = 127;
    localparam int SP_EMIN = -126;
    localparam int DP_EXP_W = 11;
    localparam int DP_FRAC_W = 52;
    localparam int DP_BIAS = 1023;
    localparam int DP_EMIN = -1022;
    localparam int SP_EXP_MAX = 255;
    localparam int DEN_SHIFT_MAX = 24;

    localparam logic [31:0] QNAN_SP = 32'h7FBF_FFFF;
    localparam logic [63:0] QNAN_DP = 64'h7FF7_FFFF_FFFF_FFFF;
    localparam logic [31:0] SP_MAXNORM = 32'h7F7F_FFFF;
    localparam logic [31:0] SP_INF = 32'h7F80_0000;

    localparam logic [31:0] FP_STATUS_CONTROL_REG_RESET = 32'h0004_0001;
    localparam logic [31:0] FP_STATUS_CONTROL_REG_WMASK = 32'h003F_FFFF;
    localparam int FP_STATUS_CONTROL_REG_RM_LSB = 0;
    localparam int FP_STATUS_CONTROL_REG_FLAG_LSB = 2;
    localparam int FP_STATUS_CONTROL_REG_EN_LSB = 7;
    localparam int FP_STATUS_CONTROL_REG_CAUSE_LSB = 12;
    localparam int FP_STATUS_CONTROL_REG_DN_POS = 18;
    localparam int FP_STATUS_CONTROL_REG_PR_POS = 19;

    localparam int EXC_I = 0;
    localparam int EXC_U = 1;
    localparam int EXC_O = 2;
    localparam int EXC_V = 4;

    localparam logic [1:0] RM_NEAREST = 2'h0;
    localparam logic [1:0] RM_ZERO = 2'h1;

    localparam logic [7:0] ADDR_FP_STATUS_CONTROL_REG = 8'h00;
    localparam logic [7:0] ADDR_CPUSW = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam int CPUSW_FD_POS = 0;
    localparam int FREG_WIN_BIT = 7;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [5:0] {
        CLS_ZERO = 6'h01,
        CLS_DENORM = 6'h02,
        CLS_NORMAL = 6'h04,
        CLS_INF = 6'h08,
        CLS_QNAN = 6'h10,
        CLS_SNAN = 6'h20
    } fpcls_class_t;

    typedef enum logic [4:0] {
        OP_COPY = 5'h01,
        OP_ABS = 5'h02,
        OP_NEG = 5'h04,
        OP_MOV = 5'h08,
        OP_CVT = 5'h10
    } fpcls_op_t;

    typedef enum logic [2:0] {
        EXC_NONE = 3'h1,
        EXC_DISABLE = 3'h2,
        EXC_FPU = 3'h4
    } fpcls_exc_t;

    typedef struct packed {
        logic valid;
        fpcls_op_t op;
        logic [4:0] src;
        logic [4:0] dst;
    } fpcls_req_t;

    typedef struct packed {
        logic valid;
        fpcls_op_t op;
        fpcls_class_t cls;
        logic sign;
        logic dbl;
        fpcls_exc_t exc;
        logic [63:0] data;
    } fpcls_rsp_t;

endpackage : fpcls_pkg

// File: core/fpcls_core.sv
// What this block does
// - FPU-disable bit set refuses every FP operation and reports a disable exception.
// - Thirty-two single registers, also addressable as sixteen even/odd double pairs.
// - Only round-to-nearest and round-toward-zero are implemented.
// - Single operand: sign bit 31, 8-bit exponent, 23-bit fraction.
// - Double operand: sign bit 63, 11-bit exponent, 52-bit fraction.
// - Stored exponent is true exponent plus bias 127 or 1023.
// - Zero exponent with zero fraction is signed zero, else denormal.
// - All-ones exponent is NaN with nonzero fraction, infinity otherwise.
// - NaN with fraction MSB one is signaling, zero is quiet.
// - Copy, absolute value and sign invert skip all NaN checks.
// - Signaling NaN input with invalid enable clear gives quiet NaN, no exception.
// - Signaling NaN input with invalid enable set traps, destination unchanged.
// - Quiet NaN input alone gives quiet NaN and never an exception.
// - Generated single quiet NaN is always 7FBFFFFF.
// - Generated double quiet NaN is 7FF7FFFF FFFFFFFF.
// - Denormal is detected as zero exponent with nonzero fraction.
// - Flush bit set replaces denormal operands and results of value ops by zero.
// - Flush bit clear keeps denormal operands and results at full value.
// - Flush bit lives in the status/control register; one flushes.
// - Rounding selector 00 is nearest, 01 toward zero, others reserved.
// - Cause field clears at each operation start unless the FPU-disable bit is set; exceptions set cause and sticky flag.
module fpcls_core
    import fpcls_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire fpcls_req_t req,
    output fpcls_rsp_t rsp
);

    typedef struct packed {
        logic [FPCLS_NREG-1:0][31:0] freg;
        logic [31:0] fp_status_control_reg;
        logic fd;
        fpcls_rsp_t rsp;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } fpcls_state_t;

    fpcls_state_t q;
    fpcls_state_t d;

    function automatic logic [31:0] fpcls_merge(input logic [31:0] old, input logic [31:0] nw,
                                                input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction : fpcls_merge

    function automatic fpcls_class_t fpcls_classify(input logic e_zero, input logic e_ones,
                                                   input logic f_nz, input logic f_msb);
        if (e_zero) begin
            return f_nz ? CLS_DENORM : CLS_ZERO;
        end else if (e_ones) begin
            if (!f_nz) begin
                return CLS_INF;
            end
            return f_msb ? CLS_SNAN : CLS_QNAN;
        end
        return CLS_NORMAL;
    endfunction : fpcls_classify

    // Operand fetch and field split; doubles are {even, odd} pairs with even on top
    logic dn;
    logic [1:0] rm;
    logic [4:0] en;
    logic dbl_src;
    logic dbl_dst;
    logic [63:0] opnd;
    logic sgn;
    logic [10:0] expf;
    logic exp_ones;
    logic [51:0] frac;
    fpcls_class_t cls;

    assign dn = q.fp_status_control_reg[FP_STATUS_CONTROL_REG_DN_POS];
    assign rm = q.fp_status_control_reg[FP_STATUS_CONTROL_REG_RM_LSB +: 2];
    assign en = q.fp_status_control_reg[FP_STATUS_CONTROL_REG_EN_LSB +: 5];
    assign dbl_src = (req.op == OP_CVT) || q.fp_status_control_reg[FP_STATUS_CONTROL_REG_PR_POS];
    assign dbl_dst = (req.op != OP_CVT) && q.fp_status_control_reg[FP_STATUS_CONTROL_REG_PR_POS];
    assign opnd = dbl_src ? {q.freg[{req.src[4:1], 1'b0}], q.freg[{req.src[4:1], 1'b1}]}
                          : {32'h0000_0000, q.freg[req.src]};
    assign sgn = dbl_src ? opnd[63] : opnd[31];
    assign expf = dbl_src ? opnd[62:52] : {3'h0, opnd[30:23]};
    assign exp_ones = dbl_src ? (&opnd[62:52]) : (&opnd[30:23]);
    assign frac = dbl_src ? opnd[51:0] : {opnd[22:0], 29'h0};
    assign cls = fpcls_classify(expf == 11'h000, exp_ones, |frac, frac[51]);

    // Double to single narrowing with rounding
    logic signed [12:0] cvt_e;
    logic signed [12:0] cvt_er;
    logic signed [12:0] cvt_sh;
    logic [22:0] cvt_m;
    logic cvt_g;
    logic cvt_st;
    logic cvt_inc;
    logic [23:0] cvt_sum;
    logic [23:0] cvt_den;

    assign cvt_e = $signed({2'h0, expf}) - $signed(13'(DP_BIAS - SP_BIAS));
    assign cvt_m = frac[51:29];
    assign cvt_g = frac[28];
    assign cvt_st = |frac[27:0];
    // Reserved selector codes fall back to truncation
    assign cvt_inc = (rm == RM_NEAREST) && cvt_g && (cvt_st || cvt_m[0]);
    assign cvt_sum = {1'b0, cvt_m} + {23'h000000, cvt_inc};
    assign cvt_er = cvt_e + $signed({12'h000, cvt_sum[23]});
    assign cvt_sh = 13'sd1 - cvt_e;
    assign cvt_den = (cvt_sh > $signed(13'(DEN_SHIFT_MAX))) ? 24'h000000
                                                            : ({1'b1, cvt_m} >> cvt_sh[4:0]);

    logic [63:0] res;
    logic [5:0] cause;
    logic wr;

    always_comb begin
        d = q;
        res = opnd;
        cause = 6'h00;
        wr = 1'b0;

        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        d.awready = 1'b0;
        d.wready = 1'b0;
        if (s_axi_awvalid && s_axi_wvalid && !q.awready && !q.bvalid) begin
            d.awready = 1'b1;
            d.wready = 1'b1;
        end
        if (q.awready && s_axi_awvalid && s_axi_wvalid) begin
            d.bvalid = 1'b1;
            d.bresp = RESP_OKAY;
            if (s_axi_awaddr[FREG_WIN_BIT]) begin
                d.freg[s_axi_awaddr[6:2]] = fpcls_merge(q.freg[s_axi_awaddr[6:2]],
                                                        s_axi_wdata, s_axi_wstrb);
            end else if ({s_axi_awaddr[7:2], 2'h0} == ADDR_FP_STATUS_CONTROL_REG) begin
                d.fp_status_control_reg = fpcls_merge(q.fp_status_control_reg, s_axi_wdata, s_axi_wstrb) & FP_STATUS_CONTROL_REG_WMASK;
            end else if ({s_axi_awaddr[7:2], 2'h0} == ADDR_CPUSW) begin
                if (s_axi_wstrb[0]) begin
                    d.fd = s_axi_wdata[CPUSW_FD_POS];
                end
            end else begin
                d.bresp = RESP_SLVERR;
            end
        end

        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        d.arready = 1'b0;
        if (s_axi_arvalid && !q.arready && !q.rvalid) begin
            d.arready = 1'b1;
        end
        if (q.arready && s_axi_arvalid) begin
            d.rvalid = 1'b1;
            d.rresp = RESP_OKAY;
            d.rdata = 32'h0000_0000;
            if (s_axi_araddr[FREG_WIN_BIT]) begin
                d.rdata = q.freg[s_axi_araddr[6:2]];
            end else if ({s_axi_araddr[7:2], 2'h0} == ADDR_FP_STATUS_CONTROL_REG) begin
                d.rdata = q.fp_status_control_reg;
            end else if ({s_axi_araddr[7:2], 2'h0} == ADDR_CPUSW) begin
                d.rdata[CPUSW_FD_POS] = q.fd;
            end else if ({s_axi_araddr[7:2], 2'h0} == ADDR_STATUS) begin
                d.rdata = {20'h00000, q.rsp.exc, q.rsp.sign, q.rsp.cls, q.rsp.dbl, q.rsp.valid};
            end else begin
                d.rresp = RESP_SLVERR;
            end
        end

        // Operation issue; runs after the bus write so hardware updates win
        d.rsp.valid = 1'b0;
        if (req.valid) begin
            d.rsp.valid = 1'b1;
            d.rsp.op = req.op;
            d.rsp.cls = cls;
            d.rsp.sign = sgn;
            d.rsp.dbl = dbl_dst;
            d.rsp.exc = EXC_NONE;
            d.rsp.data = 64'h0;
            if (q.fd) begin
                d.rsp.exc = EXC_DISABLE;
            end else begin
                wr = 1'b1;
                case (req.op)
                    OP_COPY: begin
                        res = opnd;
                    end
                    OP_ABS: begin
                        if (dbl_src) begin
                            res[63] = 1'b0;
                        end else begin
                            res[31] = 1'b0;
                        end
                    end
                    OP_NEG: begin
                        if (dbl_src) begin
                            res[63] = ~opnd[63];
                        end else begin
                            res[31] = ~opnd[31];
                        end
                    end
                    OP_MOV, OP_CVT: begin
                        if (cls == CLS_SNAN) begin
                            cause[EXC_V] = en[EXC_V];
                            res = dbl_dst ? QNAN_DP : {32'h0, QNAN_SP};
                        end else if (cls == CLS_QNAN) begin
                            res = dbl_dst ? QNAN_DP : {32'h0, QNAN_SP};
                        end else if (cls == CLS_ZERO || (cls == CLS_DENORM && dn)) begin
                            // Flushed operands keep their sign
                            res = dbl_dst ? {sgn, 63'h0} : {32'h0, sgn, 31'h0};
                        end else if (req.op == OP_MOV) begin
                            res = opnd;
                        end else if (cls == CLS_INF) begin
                            res = {32'h0, SP_INF | {sgn, 31'h0}};
                        end else if (cvt_er >= $signed(13'(SP_EXP_MAX))) begin
                            cause[EXC_O] = 1'b1;
                            cause[EXC_I] = 1'b1;
                            res = {32'h0, (rm == RM_NEAREST ? SP_INF : SP_MAXNORM)
                                          | {sgn, 31'h0}};
                        end else if (cvt_e <= 13'sd0) begin
                            cause[EXC_U] = 1'b1;
                            cause[EXC_I] = 1'b1;
                            res = dn ? {32'h0, sgn, 31'h0}
                                     : {32'h0, sgn, 8'h00, cvt_den[22:0]};
                        end else begin
                            cause[EXC_I] = cvt_g | cvt_st;
                            res = {32'h0, sgn, cvt_er[7:0], cvt_sum[22:0]};
                        end
                    end
                    default: begin
                        wr = 1'b0;
                    end
                endcase
                if (|(cause[4:0] & en)) begin
                    d.rsp.exc = EXC_FPU;
                    wr = 1'b0;
                end else begin
                    d.rsp.data = res;
                end
                // Cause restarts at zero per operation, flags accumulate
                d.fp_status_control_reg[FP_STATUS_CONTROL_REG_CAUSE_LSB +: 6] = cause;
                d.fp_status_control_reg[FP_STATUS_CONTROL_REG_FLAG_LSB +: 5] = d.fp_status_control_reg[FP_STATUS_CONTROL_REG_FLAG_LSB +: 5] | cause[4:0];
                if (wr) begin
                    if (dbl_dst) begin
                        d.freg[{req.dst[4:1], 1'b0}] = res[63:32];
                        d.freg[{req.dst[4:1], 1'b1}] = res[31:0];
                    end else begin
                        d.freg[req.dst] = res[31:0];
                    end
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.fp_status_control_reg <= FP_STATUS_CONTROL_REG_RESET;
            q.rsp.op <= OP_COPY;
            q.rsp.cls <= CLS_ZERO;
            q.rsp.exc <= EXC_NONE;
        end else begin
            q <= d;
        end
    end

    assign s_axi_awready = q.awready;
    assign s_axi_wready = q.wready;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = q.arready;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign rsp = q.rsp;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    chk_disable_blocks: assert property (req.valid && q.fd |=> rsp.valid && rsp.exc == EXC_DISABLE)
        else $error("disabled unit executed an operation");
    chk_sp_qnan_value: assert property (rsp.valid && rsp.exc == EXC_NONE && !rsp.dbl
        && (rsp.op == OP_MOV || rsp.op == OP_CVT) && (rsp.cls == CLS_SNAN || rsp.cls == CLS_QNAN)
        |-> rsp.data[31:0] == QNAN_SP)
        else $error("single quiet NaN encoding wrong");
    chk_dp_qnan_value: assert property (rsp.valid && rsp.exc == EXC_NONE && rsp.dbl
        && rsp.op == OP_MOV && rsp.cls inside {CLS_SNAN, CLS_QNAN}
        |-> rsp.data == QNAN_DP)
        else $error("double quiet NaN encoding wrong");
    chk_snan_trap: assert property (req.valid && !q.fd && cls == CLS_SNAN && en[EXC_V]
        && req.op inside {OP_MOV, OP_CVT} |=> rsp.exc == EXC_FPU
        && q.fp_status_control_reg[FP_STATUS_CONTROL_REG_CAUSE_LSB + EXC_V] && $stable(q.freg))
        else $error("signaling NaN did not trap or changed registers");
    chk_qnan_quiet: assert property (req.valid && !q.fd && cls == CLS_QNAN
        |=> rsp.exc == EXC_NONE)
        else $error("quiet NaN raised an exception");
    chk_class_onehot: assert property (rsp.valid |-> $onehot(rsp.cls))
        else $error("class code not one-hot");
    chk_flush_zero: assert property (req.valid && !q.fd && req.op == OP_MOV && cls == CLS_DENORM
        && dn |=> rsp.data[62:0] == (rsp.dbl ? 63'h0 : {31'h0, rsp.sign, 31'h0}))
        else $error("denormal not flushed");
    chk_keep_denorm: assert property (req.valid && !q.fd && req.op == OP_MOV && cls == CLS_DENORM
        && !dn |=> rsp.data == $past(opnd))
        else $error("denormal altered without flush");
    chk_pass_no_check: assert property (req.valid && !q.fd && req.op inside {OP_COPY, OP_ABS, OP_NEG}
        |=> rsp.exc == EXC_NONE && q.fp_status_control_reg[FP_STATUS_CONTROL_REG_CAUSE_LSB +: 6] == 6'h00)
        else $error("pass-through operation checked its operand");
    chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");

    cov_disable: cover property (req.valid && q.fd);
    cov_snan_trap: cover property (rsp.valid && rsp.exc == EXC_FPU);
    cov_cvt_round: cover property (req.valid && !q.fd && req.op == OP_CVT && cvt_inc);

endmodule : fpcls_core

// File: dv/fpcls_cpu_model.sv
module fpcls_cpu_model
    import fpcls_pkg::*;
(
    input wire logic aclk,
    input wire fpcls_rsp_t rsp,
    output fpcls_req_t req
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        req = '0;
    end

    // Issue one operation, then take the response one cycle after the issue edge
    task automatic issue(input fpcls_op_t op, input logic [4:0] src, input logic [4:0] dst,
                         output fpcls_rsp_t r);
        @(posedge aclk);
        req <= '{valid: 1'b1, op: op, src: src, dst: dst};
        @(posedge aclk);
        req.valid <= 1'b0;
        // Released fields carry junk so a late sample of them is caught
        req.src <= ~src;
        req.dst <= ~dst;
        @(posedge aclk);
        r = rsp;
    endtask : issue
endmodule : fpcls_cpu_model

// File: dv/fpcls_bench.sv
module fpcls_bench import fpcls_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [31:0] ctl;
        logic [31:0] val;
        fpcls_op_t op;
        fpcls_class_t cls;
        fpcls_exc_t exc;
        logic [31:0] res;
    } fpcls_row_t;

    logic aclk;
    logic aresetn;
    logic [7:0] s_axi_awaddr;
    logic s_axi_awvalid;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata;
    logic s_axi_wvalid;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready;
    logic [7:0] s_axi_araddr;
    logic s_axi_arvalid;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready;
    fpcls_req_t req;
    fpcls_rsp_t rsp;
    fpcls_rsp_t r;
    logic [1:0] resp;
    logic [31:0] d;
    int err_count = 0;
    int cmp_count = 0;

    fpcls_row_t rows [15] = '{
        '{32'h0, 32'h0, OP_MOV, CLS_ZERO, EXC_NONE, 32'h0},
        '{32'h0, 32'h8000_0000, OP_MOV, CLS_ZERO, EXC_NONE, 32'h8000_0000},
        '{32'h0, 32'h0000_0001, OP_MOV, CLS_DENORM, EXC_NONE, 32'h0000_0001},
        '{32'h0004_0000, 32'h807F_FFFF, OP_MOV, CLS_DENORM, EXC_NONE, 32'h8000_0000},
        '{32'h0004_0000, 32'h807F_FFFF, OP_COPY, CLS_DENORM, EXC_NONE, 32'h807F_FFFF},
        '{32'h0004_0000, 32'h0000_0001, OP_NEG, CLS_DENORM, EXC_NONE, 32'h8000_0001},
        '{32'h0, 32'h3F80_0000, OP_MOV, CLS_NORMAL, EXC_NONE, 32'h3F80_0000},
        '{32'h0, 32'h0080_0000, OP_MOV, CLS_NORMAL, EXC_NONE, 32'h0080_0000},
        '{32'h0, 32'hFF80_0000, OP_MOV, CLS_INF, EXC_NONE, 32'hFF80_0000},
        '{32'h0, 32'h7F80_0001, OP_MOV, CLS_QNAN, EXC_NONE, 32'h7FBF_FFFF},
        '{32'h0000_0800, 32'hFFBF_FFFF, OP_MOV, CLS_QNAN, EXC_NONE, 32'h7FBF_FFFF},
        '{32'h0, 32'hFFC0_0000, OP_MOV, CLS_SNAN, EXC_NONE, 32'h7FBF_FFFF},
        '{32'h0000_0800, 32'h7FFF_FFFF, OP_MOV, CLS_SNAN, EXC_FPU, 32'h0},
        '{32'h0000_0800, 32'h7FC0_0000, OP_NEG, CLS_SNAN, EXC_NONE, 32'hFFC0_0000},
        '{32'h0000_0800, 32'hFFC0_0000, OP_ABS, CLS_SNAN, EXC_NONE, 32'h7FC0_0000}
    };

    fpcls_core fpcls_core_i (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .req(req), .rsp(rsp)
    );

    fpcls_cpu_model fpcls_cpu_model_i (.aclk(aclk), .rsp(rsp), .req(req));

    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up

    task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axi_read

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        axi_write(a, v, resp);
        check(resp, RESP_OKAY, "write response");
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        axi_read(a, d, resp);
        check(resp, RESP_OKAY, "read response");
        check(d, exp, "read data");
    endtask : rd_chk

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    // Generous: the whole sequence needs well under two thousand cycles
    initial begin
        repeat (5000) @(posedge aclk);
        err_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        wrap_up();
    end

    initial begin
        aresetn = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = 8'h00;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        check(rsp.valid, 1'b0, "response idle after reset");
        rd_chk(ADDR_FP_STATUS_CONTROL_REG, FP_STATUS_CONTROL_REG_RESET);
        rd_chk(ADDR_CPUSW, 32'h0);
        $display("test reset done");

        foreach (rows[i]) begin
            wr(ADDR_FP_STATUS_CONTROL_REG, rows[i].ctl);
            wr(8'h84, rows[i].val);
            wr(8'h88, 32'h0BAD_F00D);
            fpcls_cpu_model_i.issue(rows[i].op, 5'h01, 5'h02, r);
            check(r.valid, 1'b1, "response valid");
            check(r.cls, rows[i].cls, "class");
            check(r.sign, rows[i].val[31], "sign");
            check(r.dbl, 1'b0, "precision");
            check(r.exc, rows[i].exc, "exception");
            check(r.op, rows[i].op, "operation echo");
            check(r.data, {32'h0, rows[i].res}, "result");
            rd_chk(8'h88, (rows[i].exc == EXC_FPU) ? 32'h0BAD_F00D : rows[i].res);
        end
        $display("test rows done");

        wr(ADDR_FP_STATUS_CONTROL_REG, 32'h0000_0800);
        wr(8'h84, 32'hFFC0_0000);
        fpcls_cpu_model_i.issue(OP_MOV, 5'h01, 5'h02, r);
        rd_chk(ADDR_FP_STATUS_CONTROL_REG, 32'h0001_0840);
        fpcls_cpu_model_i.issue(OP_COPY, 5'h01, 5'h02, r);
        rd_chk(ADDR_FP_STATUS_CONTROL_REG, 32'h0000_0840);
        $display("test cause done");

        wr(ADDR_CPUSW, 32'h0000_0001);
        wr(8'h88, 32'h0BAD_F00D);
        fpcls_cpu_model_i.issue(OP_MOV, 5'h01, 5'h02, r);
        check(r.exc, EXC_DISABLE, "disable exception");
        rd_chk(8'h88, 32'h0BAD_F00D);
        rd_chk(ADDR_FP_STATUS_CONTROL_REG, 32'h0000_0840);
        wr(ADDR_CPUSW, 32'h0);
        $display("test disable done");

        wr(ADDR_FP_STATUS_CONTROL_REG, 32'h0008_0000);
        wr(8'h90, 32'h7FF8_0000);
        wr(8'h94, 32'h0);
        fpcls_cpu_model_i.issue(OP_MOV, 5'h04, 5'h06, r);
        check(r.cls, CLS_SNAN, "double class");
        check(r.dbl, 1'b1, "double flag");
        check(r.data, QNAN_DP, "double result");
        rd_chk(8'h98, 32'h7FF7_FFFF);
        rd_chk(8'h9C, 32'hFFFF_FFFF);
        rd_chk(ADDR_STATUS, 32'h0000_0282);
        $display("test double done");

        axi_read(8'h40, d, resp);
        check(resp, RESP_SLVERR, "unmapped read response");
        check(d, 32'h0, "unmapped read data");
        axi_write(ADDR_STATUS, 32'h0, resp);
        check(resp, RESP_SLVERR, "read-only write response");
        $display("test bus done");

        // 1.0 plus one and a half single ulps: nearest rounds up, toward zero truncates
        wr(ADDR_FP_STATUS_CONTROL_REG, 32'h0000_0000);
        wr(8'h90, 32'h3FF0_0000);
        wr(8'h94, 32'h3000_0000);
        fpcls_cpu_model_i.issue(OP_CVT, 5'h04, 5'h06, r);
        check(r.cls, CLS_NORMAL, "convert class");
        check(r.dbl, 1'b0, "convert precision");
        check(r.data, 64'h0000_0000_3F80_0002, "convert nearest");
        rd_chk(ADDR_FP_STATUS_CONTROL_REG, 32'h0000_1004);
        wr(ADDR_FP_STATUS_CONTROL_REG, 32'h0000_0001);
        fpcls_cpu_model_i.issue(OP_CVT, 5'h04, 5'h06, r);
        check(r.data, 64'h0000_0000_3F80_0001, "convert toward zero");
        rd_chk(8'h98, 32'h3F80_0001);
        $display("test convert done");

        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        check(rsp.valid, 1'b0, "response idle after second reset");
        rd_chk(ADDR_FP_STATUS_CONTROL_REG, FP_STATUS_CONTROL_REG_RESET);
        rd_chk(8'h98, 32'h0);
        $display("test second reset done");
        wrap_up();
    end
endmodule : fpcls_bench
